//--- inc/alert_pkg.sv
package alert_pkg;

  // alert response address, 7 bits, read direction appended on the wire
  localparam logic [6:0] ARA_ADDR       = 7'h0C;
  localparam logic [7:0] ARA_READ_BYTE  = {ARA_ADDR, 1'b1};
  // polarity select: 0 means active low, the power-up default
  localparam logic       IRQ_POL_RESET  = 1'b0;
  // disable select: 1 releases the output, 0 enables it
  localparam logic       IRQ_DIS_RESET  = 1'b0;
  localparam int         BYTE_BITS      = 8;
  localparam logic [3:0] BIT_CNT_RESET  = 4'h0;
  localparam logic [3:0] BIT_CNT_LAST   = 4'h8;

  // configuration bits held elsewhere in the device
  typedef struct packed {
    logic i2c_mode;          // two-wire interface selected
    logic irq_polarity_bit;  // 1 = active high, 0 = active low
    logic irq_disable_bit;   // 1 = output released
  } cfg_t;

  // two-wire bus levels as sampled from the pads
  typedef struct packed {
    logic scl;
    logic sda;
  } bus_in_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ADDR = 5'b00010,
    ST_ACK  = 5'b00100,
    ST_DATA = 5'b01000,
    ST_MACK = 5'b10000
  } ara_state_t;

endpackage

//--- hdl/smbus_alert_response.sv
`timescale 1ns/100ps

// Notes on behaviour
// - in two-wire mode the interrupt output acts as an alert line
// - alert pin only pulls low or releases; shared line is wired-and
// - asserting device acks that address and returns its address with lsb 1
// - lowest address wins return by bitwise arbitration; losers yield
// - release only after fault cleared and status read, and in two-wire mode also after answering
// - polarity bit selects level, default active low; disable bit releases output
// - alert sets when any measurement leaves its limits
module smbus_alert_response
  import alert_pkg::*;
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_n,
  input  wire cfg_t       i_cfg,
  input  wire logic [6:0] i_dev_addr,
  input  wire logic       i_limit_fault,
  input  wire logic       i_status_read,
  input  wire bus_in_t    i_bus,
  output logic            o_sda_out,
  output logic            o_sda_oe,
  output logic            o_alert_out,
  output logic            o_alert_oe,
  output logic            o_alert_active,
  output logic            o_ara_answered
);

  ////////////////////////////////////////////////////////////////////////
  // bus edge detection

  bus_in_t bus_q;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      bus_q <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      bus_q <= i_bus;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  assign scl_rise  = i_bus.scl & ~bus_q.scl;
  assign scl_fall  = ~i_bus.scl & bus_q.scl;
  assign bus_start = i_bus.scl & bus_q.scl & bus_q.sda & ~i_bus.sda;
  assign bus_stop  = i_bus.scl & bus_q.scl & ~bus_q.sda & i_bus.sda;

  ////////////////////////////////////////////////////////////////////////
  // alert response responder

  ara_state_t state;
  ara_state_t next_state;
  logic [7:0] rx;
  logic [7:0] next_rx;
  logic [7:0] tx;
  logic [7:0] next_tx;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic       sda_oe;
  logic       next_sda_oe;
  logic       answered_pulse;
  logic       next_answered_pulse;
  logic       alert_active;

  always_comb begin
    next_state          = state;
    next_rx             = rx;
    next_tx             = tx;
    next_bit_cnt        = bit_cnt;
    next_sda_oe         = sda_oe;
    next_answered_pulse = 1'b0;
    if (!i_cfg.i2c_mode || bus_stop) begin
      next_state  = ST_IDLE;
      next_sda_oe = 1'b0;
    end else if (bus_start) begin
      next_state   = ST_ADDR;
      next_bit_cnt = BIT_CNT_RESET;
      next_sda_oe  = 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
        end
        ST_ADDR: begin
          if (scl_rise) begin
            next_rx      = {rx[6:0], i_bus.sda};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == BIT_CNT_LAST) begin
            // only a device with its alert up claims the response address
            if (rx == ARA_READ_BYTE && alert_active) begin
              next_state  = ST_ACK;
              next_sda_oe = 1'b1;
            end else begin
              next_state = ST_IDLE;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            next_tx      = {i_dev_addr, 1'b1};
            next_sda_oe  = ~i_dev_addr[6];
            next_bit_cnt = BIT_CNT_RESET;
            next_state   = ST_DATA;
          end
        end
        ST_DATA: begin
          if (scl_rise) begin
            // released a one but the line reads zero: a lower address won
            if (!sda_oe && !i_bus.sda) begin
              next_state = ST_IDLE;
            end else begin
              next_bit_cnt = bit_cnt + 4'h1;
            end
          end else if (scl_fall) begin
            if (bit_cnt == BIT_CNT_LAST) begin
              next_sda_oe         = 1'b0;
              next_answered_pulse = 1'b1;
              next_state          = ST_MACK;
            end else begin
              next_tx     = {tx[6:0], 1'b1};
              next_sda_oe = ~tx[6];
            end
          end
        end
        ST_MACK: begin
          if (scl_fall) begin
            next_state = ST_IDLE;
          end
        end
        default: begin
          next_state  = ST_IDLE;
          next_sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      state          <= ST_IDLE;
      rx             <= 8'h00;
      tx             <= 8'hFF;
      bit_cnt        <= BIT_CNT_RESET;
      sda_oe         <= 1'b0;
      answered_pulse <= 1'b0;
    end else begin
      state          <= next_state;
      rx             <= next_rx;
      tx             <= next_tx;
      bit_cnt        <= next_bit_cnt;
      sda_oe         <= next_sda_oe;
      answered_pulse <= next_answered_pulse;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // alert latch and pin drive

  logic answered;
  logic next_answered;
  logic status_seen;
  logic next_status_seen;
  logic next_alert_active;
  logic next_alert_oe;
  logic alert_oe;
  logic release_ok;

  // in the four-wire mode there is no response read to wait for
  assign release_ok = ~i_limit_fault & status_seen & (answered | ~i_cfg.i2c_mode);

  always_comb begin
    next_alert_active = alert_active;
    next_answered     = answered | next_answered_pulse;
    next_status_seen  = status_seen | i_status_read;
    if (i_limit_fault) begin
      // a fault arriving with a release pending keeps the alert up
      next_alert_active = 1'b1;
      if (!alert_active) begin
        next_answered    = 1'b0;
        next_status_seen = i_status_read;
      end
    end else if (alert_active && release_ok) begin
      next_alert_active = 1'b0;
      // set wins over the release clear; a fresh fault discards it anyway
      next_answered     = next_answered_pulse;
      next_status_seen  = i_status_read;
    end
    // a lost arbitration leaves alert_active untouched for the next read
    // polarity high means asserted level is released, idle level pulled low
    next_alert_oe = ~i_cfg.irq_disable_bit & (next_alert_active ^ i_cfg.irq_polarity_bit);
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      alert_active <= 1'b0;
      answered     <= 1'b0;
      status_seen  <= 1'b0;
      alert_oe     <= 1'b0;
    end else begin
      alert_active <= next_alert_active;
      answered     <= next_answered;
      status_seen  <= next_status_seen;
      alert_oe     <= next_alert_oe;
    end
  end

  // pad data stays low; only the enables move, so nothing ever drives high
  always_ff @(posedge i_clk_sys) begin
    o_sda_out   <= 1'b0;
    o_alert_out <= 1'b0;
  end

  assign o_sda_oe       = sda_oe;
  assign o_alert_oe     = alert_oe;
  assign o_alert_active = alert_active;
  assign o_ara_answered = answered_pulse;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  a_fault_sets_alert: assert property (
    i_limit_fault |=> alert_active)
    else $error("alert not set after limit fault");

  a_release_after_read: assert property (
    $fell(alert_active) |-> $past(status_seen) && !$past(i_limit_fault))
    else $error("alert released without status read or with fault");

  a_release_after_ara: assert property (
    $fell(alert_active) && $past(i_cfg.i2c_mode) |-> $past(answered))
    else $error("alert released before response read answered");

  a_pads_never_high: assert property (
    ##1 (!o_sda_out && !o_alert_out))
    else $error("pad data driven high");

  a_alert_pin_low: assert property (
    (alert_active && !i_cfg.irq_disable_bit && !i_cfg.irq_polarity_bit) [*2] |-> o_alert_oe)
    else $error("active low alert not pulling line");

  a_alert_disabled: assert property (
    i_cfg.irq_disable_bit [*2] |-> !o_alert_oe)
    else $error("disabled alert output still driving");

  a_ack_only_ara: assert property (
    state == ST_ACK |-> rx == ARA_READ_BYTE && o_sda_oe && $past(alert_active))
    else $error("acknowledged address other than response address");

  a_data_bit_drive: assert property (
    state == ST_DATA |-> o_sda_oe == ~tx[7])
    else $error("returned bit does not match address byte");

  a_lost_yields: assert property (
    state == ST_DATA && scl_rise && !o_sda_oe && !i_bus.sda && !i_limit_fault
      && i_cfg.i2c_mode && !bus_stop && !bus_start
      |=> state == ST_IDLE && !o_sda_oe && alert_active)
    else $error("arbitration loser kept driving or dropped its alert");

  a_two_wire_only: assert property (
    !i_cfg.i2c_mode |=> state == ST_IDLE && !o_sda_oe)
    else $error("responder active outside two-wire mode");

  c_ara_answered: cover property (o_ara_answered);
  c_arb_lost: cover property (state == ST_DATA ##1 state == ST_IDLE && alert_active);
  c_alert_release: cover property ($fell(alert_active) && i_cfg.i2c_mode);
  c_repeat_read: cover property (o_ara_answered ##[1:1000] state == ST_ACK);

endmodule

//--- verification/smbus_host_model.sv
`timescale 1ns/100ps
module smbus_host_model
  import alert_pkg::*;
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_sda_oe,
  input  wire logic       i_rival_on,
  input  wire logic [6:0] i_rival_addr,
  output bus_in_t         o_bus
);
  logic scl = 1'b1;
  logic sda_m = 1'b1;
  logic pull = 1'b0;
  logic sda_w;
  // pulled-up wire, low if anyone pulls
  assign sda_w = sda_m & ~i_sda_oe & ~pull;
  assign o_bus = {scl, sda_w};

  //////////////////////////////////////////////////////////////////////
  // 4 clocks per scl phase leaves margin over the 2-clock minimum
  task automatic step(input logic c, input logic d, input logic r);
    @(posedge i_clk_sys);
    scl <= c;
    sda_m <= d;
    pull <= r;
    repeat (3) @(posedge i_clk_sys);
    #1;
  endtask

  task automatic ara_read(output logic [7:0] rx, output logic ack);
    logic       live;
    logic [7:0] rb;
    live = i_rival_on;
    rb = {i_rival_addr, 1'b1};
    step(1'b1, 1'b1, 1'b0);
    step(1'b1, 1'b0, 1'b0);
    for (int i = 7; i >= 0; i--) begin
      step(1'b0, ARA_READ_BYTE[i], 1'b0);
      step(1'b1, ARA_READ_BYTE[i], 1'b0);
    end
    step(1'b0, 1'b1, live);
    step(1'b1, 1'b1, live);
    ack = ~sda_w;
    for (int i = 7; i >= 0; i--) begin
      step(1'b0, 1'b1, live & ~rb[i]);
      step(1'b1, 1'b1, live & ~rb[i]);
      rx[i] = sda_w;
      if (rb[i] && !sda_w) live = 1'b0;
    end
    step(1'b0, 1'b1, 1'b0);
    step(1'b1, 1'b1, 1'b0);
    step(1'b0, 1'b0, 1'b0);
    step(1'b1, 1'b0, 1'b0);
    step(1'b1, 1'b1, 1'b0);
  endtask
endmodule

//--- verification/smbus_alert_response_test.sv
`timescale 1ns/100ps
module smbus_alert_response_test
  import alert_pkg::*;
;
  logic       i_clk_sys = 1'b0;
  logic       i_rst_n = 1'b0;
  cfg_t       i_cfg = 3'h4;
  logic [6:0] i_dev_addr = 7'h48;
  logic       i_limit_fault = 1'b0;
  logic       i_status_read = 1'b0;
  logic       rival_on = 1'b0;
  bus_in_t    i_bus;
  logic       o_sda_out, o_sda_oe, o_alert_out, o_alert_oe, o_alert_active;
  logic       o_ara_answered, ack;
  logic [7:0] rx;
  int         mismatches = 0;
  int         n_checks = 0;
  int         pulses = 0;

  smbus_alert_response smbus_alert_response_inst (.i_clk_sys, .i_rst_n, .i_cfg,
    .i_dev_addr, .i_limit_fault, .i_status_read, .i_bus, .o_sda_out, .o_sda_oe,
    .o_alert_out, .o_alert_oe, .o_alert_active, .o_ara_answered);
  smbus_host_model smbus_host_model_inst (.i_clk_sys, .i_sda_oe(o_sda_oe),
    .i_rival_on(rival_on), .i_rival_addr(7'h20), .o_bus(i_bus));

  initial forever #25 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) if (o_ara_answered === 1'b1) pulses++;

  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic fault;
    @(posedge i_clk_sys) i_limit_fault <= 1'b1;
    @(posedge i_clk_sys) i_limit_fault <= 1'b0;
    #1 chk(o_alert_oe, 8'h01);
  endtask

  // status read, then let a possible release land
  task automatic rd;
    @(posedge i_clk_sys) i_status_read <= 1'b1;
    @(posedge i_clk_sys) i_status_read <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    #1;
  endtask

  task automatic ara;
    smbus_host_model_inst.ara_read(rx, ack);
  endtask

  //////////////////////////////////////////////////////////////////////
  task automatic t_one;
    int p;
    fault();
    p = pulses;
    ara();
    chk(ack, 8'h01);
    chk(rx, {i_dev_addr, 1'b1});
    chk(8'(pulses - p), 8'h01);
    chk(o_alert_oe, 8'h01);
    chk(o_alert_active, 8'h01);
    rd();
    chk(o_alert_oe, 8'h00);
    chk(o_alert_active, 8'h00);
    ara();
    chk(ack, 8'h00);
  endtask

  task automatic t_held;
    @(posedge i_clk_sys) i_limit_fault <= 1'b1;
    rd();
    ara();
    chk(o_alert_oe, 8'h01);
    @(posedge i_clk_sys) i_limit_fault <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    #1 chk(o_alert_oe, 8'h00);
  endtask

  // rival at lower address shares the wired-and data line
  task automatic t_arb;
    int p;
    rival_on <= 1'b1;
    fault();
    p = pulses;
    ara();
    chk(rx, 8'h41);
    chk(8'(pulses - p), 8'h00);
    chk(o_alert_oe, 8'h01);
    chk(o_alert_active, 8'h01);
    rival_on <= 1'b0;
    rd();
    ara();
    chk(rx, {i_dev_addr, 1'b1});
    repeat (2) @(posedge i_clk_sys);
    #1 chk(o_alert_oe, 8'h00);
  endtask

  task automatic t_cfg;
    @(posedge i_clk_sys) i_cfg <= 3'h0;
    fault();
    ara();
    chk(ack, 8'h00);
    rd();
    chk(o_alert_oe, 8'h00);
    @(posedge i_clk_sys) i_cfg <= 3'h6;
    repeat (3) @(posedge i_clk_sys);
    #1 chk(o_alert_oe, 8'h01);
    @(posedge i_clk_sys) i_cfg <= 3'h7;
    repeat (3) @(posedge i_clk_sys);
    #1 chk(o_alert_oe, 8'h00);
    @(posedge i_clk_sys) i_cfg <= 3'h4;
  endtask

  initial begin
    repeat (3) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    @(posedge i_clk_sys);
    #1 chk(o_alert_oe, 8'h00);
    chk({o_alert_out, o_sda_out}, 8'h00);
    t_one();
    t_held();
    t_arb();
    t_cfg();
    final_report();
  end

  initial begin
    #400000;
    mismatches++;
    final_report();
  end
endmodule
